/* File: rtl/nvsctl_pkg.sv */
package nvsctl_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // store / recall key sequence
  // ----------------------------------------------------------------
  localparam int SEQ_LEN = 6;
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0aaa;
  localparam logic [12:0] SEQ_A3 = 13'h1fff;
  localparam logic [12:0] SEQ_A4 = 13'h10f0;
  localparam logic [12:0] SEQ_STORE_A5 = 13'h0f0f;
  localparam logic [12:0] SEQ_RECALL_A5 = 13'h0f0e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STORE_BUSY_TIME_MS = 10;
  localparam int RECALL_BUSY_TIME_US = 20;
  localparam int POWERUP_RECALL_TIME_US = 550;
  localparam int STORE_BUSY_CYC = STORE_BUSY_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RECALL_BUSY_CYC = RECALL_BUSY_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERUP_RECALL_CYC =
    POWERUP_RECALL_TIME_US * 1000 / CLK_PERIOD_NS;
  // chip select low phase and high phase of each access, in cycles
  localparam int ACC_LOW_CYC = 3;
  localparam int ACC_HIGH_CYC = 1;
  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // commands and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NVS_CMD_READ,
    NVS_CMD_WRITE,
    NVS_CMD_STORE,
    NVS_CMD_RECALL
  } nvs_cmd_t;

  typedef struct packed {
    nvs_cmd_t          cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvs_req_t;

  typedef struct packed {
    logic              sel_n;
    logic              wr_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic              dq_oe_n;
  } nvs_pins_t;

endpackage : nvsctl_pkg

/* File: rtl/nvsctl_host.sv */
// What this block does
// - write strobe high reads, low writes
// - store key ends at 0F0F
// - recall key ends at 0F0E
// - write strobe high through all six
// - each key access clocked by select
`timescale 1ns/100ps
`default_nettype none

module nvsctl_host
  import nvsctl_pkg::*;
#(
  parameter int STORE_CYC   = STORE_BUSY_CYC,
  parameter int RECALL_CYC  = RECALL_BUSY_CYC,
  parameter int POWERUP_CYC = POWERUP_RECALL_CYC
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // request side
  input  wire logic              req_valid_in,
  input  wire nvs_req_t          req_in,
  input  wire logic              supply_ok_in,
  output logic                   req_ready_out,
  output logic                   rd_valid_out,
  output logic [DATA_W-1:0]      rd_data_out,
  // device pins
  output logic                   sel_n_out,
  output logic                   wr_n_out,
  output logic                   oe_n_out,
  output logic [ADDR_W-1:0]      byte_address_bus_out,
  output logic [DATA_W-1:0]      bidir_data_bus_out,
  output logic                   bidir_data_bus_oe_n_out,
  input  wire logic [DATA_W-1:0] bidir_data_bus_in
);

  // refuse wait counts that the counter cannot hold
  if (STORE_CYC < 1 || STORE_CYC >= (1 << CNT_W) ||
      RECALL_CYC < 1 || RECALL_CYC >= (1 << CNT_W) ||
      POWERUP_CYC < 1 || POWERUP_CYC >= (1 << CNT_W)) begin : g_bad_wait
    $error("nvsctl_host: wait count out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_BUSY
  } nvs_state_t;

  typedef struct packed {
    nvs_state_t        state;
    nvs_req_t          req;
    logic [2:0]        step;
    logic [CNT_W-1:0]  cnt;
    logic              ready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    nvs_pins_t         pins;
  } nvs_regs_t;

  localparam nvs_pins_t PINS_IDLE = '{sel_n: 1'b1, wr_n: 1'b1,
    oe_n: 1'b1, addr: '0, dq: '0, dq_oe_n: 1'b1};

  nvs_regs_t r;
  nvs_regs_t next_r;

  function automatic logic [ADDR_W-1:0] key_addr(input logic [2:0] step,
                                                 input nvs_cmd_t cmd);
    case (step)
      3'h0: key_addr = SEQ_A0;
      3'h1: key_addr = SEQ_A1;
      3'h2: key_addr = SEQ_A2;
      3'h3: key_addr = SEQ_A3;
      3'h4: key_addr = SEQ_A4;
      default: key_addr = (cmd == NVS_CMD_STORE) ? SEQ_STORE_A5
                                                 : SEQ_RECALL_A5;
    endcase
  endfunction

  function automatic logic is_key(input nvs_cmd_t cmd);
    is_key = (cmd == NVS_CMD_STORE) || (cmd == NVS_CMD_RECALL);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    case (r.state)
      ST_POWERUP: begin
        // wait out the device's own power-up recall
        if (!supply_ok_in) begin
          next_r.cnt = '0;
        end else if (r.cnt >= CNT_W'(POWERUP_CYC - 1)) begin
          next_r.state = ST_IDLE;
          next_r.ready = 1'b1;
          next_r.cnt = '0;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_IDLE: begin
        if (!supply_ok_in) begin
          // supply loss: device rerecalls on return
          next_r.state = ST_POWERUP;
          next_r.ready = 1'b0;
          next_r.cnt = '0;
        end else if (req_valid_in &&
            !(req_in.cmd == NVS_CMD_WRITE && !supply_ok_in) &&
            !(req_in.cmd == NVS_CMD_STORE && !supply_ok_in)) begin
          next_r.req = req_in;
          next_r.ready = 1'b0;
          next_r.step = '0;
          next_r.cnt = '0;
          next_r.state = ST_LOW;
          next_r.pins.sel_n = 1'b0;
          if (is_key(req_in.cmd)) begin
            next_r.pins.addr = key_addr(3'h0, req_in.cmd);
            next_r.pins.wr_n = 1'b1;
            next_r.pins.oe_n = 1'b1;
          end else if (req_in.cmd == NVS_CMD_WRITE) begin
            // write strobe low together with select: no output drive
            next_r.pins.addr = req_in.addr;
            next_r.pins.wr_n = 1'b0;
            next_r.pins.oe_n = 1'b1;
            next_r.pins.dq = req_in.wdata;
            next_r.pins.dq_oe_n = 1'b0;
          end else begin
            next_r.pins.addr = req_in.addr;
            next_r.pins.wr_n = 1'b1;
            next_r.pins.oe_n = 1'b0;
          end
        end
      end
      ST_LOW: begin
        if (r.cnt >= CNT_W'(ACC_LOW_CYC - 1)) begin
          next_r.cnt = '0;
          next_r.state = ST_HIGH;
          next_r.pins = PINS_IDLE;
          next_r.pins.addr = r.pins.addr;
          if (r.req.cmd == NVS_CMD_READ) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = bidir_data_bus_in;
          end
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_HIGH: begin
        if (r.cnt >= CNT_W'(ACC_HIGH_CYC - 1)) begin
          next_r.cnt = '0;
          if (is_key(r.req.cmd) && r.step < 3'(SEQ_LEN - 1)) begin
            // next key access follows directly, nothing in between
            next_r.step = r.step + 1'b1;
            next_r.state = ST_LOW;
            next_r.pins.sel_n = 1'b0;
            next_r.pins.wr_n = 1'b1;
            next_r.pins.addr = key_addr(r.step + 1'b1, r.req.cmd);
          end else if (is_key(r.req.cmd)) begin
            next_r.state = ST_BUSY;
          end else begin
            next_r.state = ST_IDLE;
            next_r.ready = 1'b1;
          end
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      ST_BUSY: begin
        // bus held idle while the nonvolatile cycle runs
        if ((r.req.cmd == NVS_CMD_STORE &&
             r.cnt >= CNT_W'(STORE_CYC - 1)) ||
            (r.req.cmd == NVS_CMD_RECALL &&
             r.cnt >= CNT_W'(RECALL_CYC - 1))) begin
          next_r.cnt = '0;
          next_r.state = ST_IDLE;
          next_r.ready = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 1'b1;
        end
      end
      default: begin
        next_r.state = ST_POWERUP;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '{state: ST_POWERUP, req: '0, step: '0, cnt: '0, ready: 1'b0,
             rvalid: 1'b0, rdata: '0, pins: PINS_IDLE};
    end else begin
      r <= next_r;
    end
  end

  assign req_ready_out           = r.ready;
  assign rd_valid_out            = r.rvalid;
  assign rd_data_out             = r.rdata;
  assign sel_n_out               = r.pins.sel_n;
  assign wr_n_out                = r.pins.wr_n;
  assign oe_n_out                = r.pins.oe_n;
  assign byte_address_bus_out    = r.pins.addr;
  assign bidir_data_bus_out      = r.pins.dq;
  assign bidir_data_bus_oe_n_out = r.pins.dq_oe_n;

endmodule // nvsctl_host

`default_nettype wire

/* File: testbench/nvsctl_host_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module nvsctl_host_sva
  import nvsctl_pkg::*;
(
  // watched ports
  input wire logic              mclk_in,
  input wire logic              rstn_in,
  input wire logic              req_valid_in,
  input wire nvs_req_t          req_in,
  input wire logic              supply_ok_in,
  input wire logic              req_ready_out,
  input wire logic              rd_valid_out,
  input wire logic              sel_n_out,
  input wire logic              wr_n_out,
  input wire logic              oe_n_out,
  input wire logic [ADDR_W-1:0] byte_address_bus_out,
  input wire logic              bidir_data_bus_oe_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic [4:0] key;
  wire take = req_ready_out & req_valid_in & supply_ok_in;
  wire st = take & (req_in.cmd == NVS_CMD_STORE);
  wire rc = take & (req_in.cmd == NVS_CMD_RECALL);
  // counts the 24 cycles of a key sequence
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      key <= 5'h00;
    end else if (st || rc) begin
      key <= 5'h18;
    end else if (key != 5'h00) begin
      key <= key - 5'h01;
    end
  end
  a_write_drive: assert property (
    !wr_n_out |-> !bidir_data_bus_oe_n_out && oe_n_out)
    else $error("write without data drive");
  a_read_quiet: assert property (
    !oe_n_out |-> wr_n_out && bidir_data_bus_oe_n_out)
    else $error("read with write strobe or drive");
  a_read_valid: assert property (
    rd_valid_out == ($rose(sel_n_out) && !$past(oe_n_out)))
    else $error("read data pulse misplaced");
  a_sel_phase: assert property (
    $fell(sel_n_out) |=>
      (!sel_n_out && $stable(byte_address_bus_out))[*2] ##1 sel_n_out)
    else $error("select phase wrong");
  a_key_first: assert property (
    st |=> !sel_n_out && byte_address_bus_out == SEQ_A0)
    else $error("key does not start at zero");
  a_store_last: assert property (
    st |-> ##21 !sel_n_out && byte_address_bus_out == SEQ_STORE_A5)
    else $error("store key end wrong");
  a_recall_last: assert property (
    rc |-> ##21 !sel_n_out && byte_address_bus_out == SEQ_RECALL_A5)
    else $error("recall key end wrong");
  a_key_reads: assert property (
    key != 5'h00 |-> wr_n_out && oe_n_out)
    else $error("write strobe low in key");
  a_key_alone: assert property (
    key != 5'h00 |-> !req_ready_out)
    else $error("request open inside key");
  a_store_idle: assert property (
    st |-> ##25 (sel_n_out && !req_ready_out)[*8])
    else $error("bus active during store");
  a_wr_supply: assert property (
    $fell(wr_n_out) |-> $past(supply_ok_in))
    else $error("write with low supply");
endmodule // nvsctl_host_sva
bind nvsctl_host nvsctl_host_sva u_sva (.*);
`default_nettype wire

/* File: testbench/nvsctl_dev_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nvsctl_dev_model
  import nvsctl_pkg::*;
(
  // device pins
  input wire logic              sel_n_in,
  input wire logic              wr_n_in,
  input wire logic              oe_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] dq_host_in,
  input wire logic              dq_oe_n_in,
  input wire logic              supply_ok_in,
  output logic     [DATA_W-1:0] dq_out
);
  logic [DATA_W-1:0] mem [8192];
  logic [DATA_W-1:0] dout = 8'h00;
  logic [ADDR_W-1:0] keys [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
  logic              drv = 1'b0;
  logic              busy = 1'b0;
  int                seq = 0;
  int                n_store = 0;
  int                n_recall = 0;
  int                n_auto = 0;
  logic              dirty = 1'b0;
  // no pull: a released bus shows the inverse of the last byte
  assign dq_out = !dq_oe_n_in ? dq_host_in : drv ? dout : ~dout;
  always @(negedge sel_n_in) begin
    #1;
    if (busy || !wr_n_in) begin
      seq = 0;
      if (!busy && supply_ok_in) begin
        mem[addr_in] = dq_host_in;
        dirty = 1'b1;
      end
    end else if (seq == 5 && addr_in[12:1] == SEQ_STORE_A5[12:1]) begin
      seq = 0;
      if (!addr_in[0] || supply_ok_in) begin
        busy = 1'b1;
        dirty = 1'b0;
        busy <= #(addr_in[0] ? 400 : 150) 1'b0;
        n_store = n_store + int'(addr_in[0]);
        n_recall = n_recall + int'(!addr_in[0]);
      end
    end else begin
      seq = (seq < 5 && addr_in == keys[seq]) ? seq + 1 :
            int'(addr_in == SEQ_A0);
      dout = mem[addr_in];
      drv = !oe_n_in;
    end
  end
  always @(posedge sel_n_in) drv = 1'b0;
  // supply return: own recall keeps the bus dead for a while
  always @(posedge supply_ok_in) begin
    busy = 1'b1;
    busy <= #150 1'b0;
  end
  // supply loss: automatic store only when written since last cycle
  always @(negedge supply_ok_in) begin
    if (dirty) n_auto = n_auto + 1;
    dirty = 1'b0;
  end
endmodule // nvsctl_dev_model
`default_nettype wire

/* File: testbench/tb_nvsctl_host.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_nvsctl_host;
  import nvsctl_pkg::*;
  logic              mclk_in = 1'b0;
  logic              rstn_in = 1'b0;
  logic              req_valid_in = 1'b0;
  nvs_req_t          req_in = '0;
  logic              supply_ok_in = 1'b1;
  logic              req_ready_out, rd_valid_out, sel_n_out, wr_n_out;
  logic              oe_n_out, bidir_data_bus_oe_n_out;
  logic [DATA_W-1:0] rd_data_out, bidir_data_bus_out, bidir_data_bus_in;
  logic [ADDR_W-1:0] byte_address_bus_out;
  int                failures = 0;
  int                cmp_count = 0;
  int                cyc = 0;
  localparam int STORE_T = 50;
  localparam int RECALL_T = 20;
  localparam int POWERUP_T = 20;
  localparam int ACC_T = ACC_LOW_CYC + ACC_HIGH_CYC;
  always #5 mclk_in = ~mclk_in;
  nvsctl_host #(.STORE_CYC(STORE_T), .RECALL_CYC(RECALL_T),
    .POWERUP_CYC(POWERUP_T)) uut (.*);
  nvsctl_dev_model dev (.sel_n_in(sel_n_out), .wr_n_in(wr_n_out),
    .oe_n_in(oe_n_out), .addr_in(byte_address_bus_out),
    .dq_host_in(bidir_data_bus_out), .dq_oe_n_in(bidir_data_bus_oe_n_out),
    .supply_ok_in(supply_ok_in), .dq_out(bidir_data_bus_in));
  task automatic complete_run;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  // holds the request to the taking edge, then counts cycles to ready
  task automatic do_req(input nvs_cmd_t c, input logic [12:0] a,
                        input logic [7:0] d, output int lat);
    lat = 0;
    while (req_ready_out !== 1'b1 && lat < 200) begin
      @(negedge mclk_in);
      lat++;
    end
    req_valid_in = 1'b1;
    req_in = '{c, a, d};
    @(negedge mclk_in);
    req_valid_in = 1'b0;
    lat = 0;
    do begin
      @(negedge mclk_in);
      lat++;
    end while (req_ready_out !== 1'b1 && lat < 2000);
  endtask
  task automatic sc_rw;
    int l;
    do_req(NVS_CMD_WRITE, 13'h0155, 8'h12, l);
    chk(16'(l), 16'(ACC_T));
    do_req(NVS_CMD_READ, 13'h0155, 8'h00, l);
    chk({8'(l), rd_data_out}, {8'(ACC_T), 8'h12});
  endtask
  task automatic sc_nv(input nvs_cmd_t c);
    int l, s, r;
    logic [15:0] e;
    s = dev.n_store;
    r = dev.n_recall;
    do_req(c, 13'h0000, 8'h00, l);
    e = 16'(SEQ_LEN * ACC_T + (c == NVS_CMD_STORE ? STORE_T : RECALL_T));
    chk(16'(l), e);
    e = (c == NVS_CMD_STORE) ? 16'h0100 : 16'h0001;
    chk({8'(dev.n_store - s), 8'(dev.n_recall - r)}, e);
    do_req(NVS_CMD_READ, 13'h0155, 8'h00, l);
    chk(16'(rd_data_out), 16'h0012);
  endtask
  task automatic sc_low;
    int l, a;
    do_req(NVS_CMD_WRITE, 13'h0155, 8'h12, l);
    a = dev.n_auto;
    supply_ok_in = 1'b0;
    req_valid_in = 1'b1;
    req_in = '{NVS_CMD_WRITE, 13'h0155, 8'h5a};
    repeat (4) begin
      @(negedge mclk_in);
      chk({14'h0000, req_ready_out, sel_n_out}, 16'h0001);
    end
    chk(16'(dev.n_auto - a), 16'h0001);
    req_valid_in = 1'b0;
    supply_ok_in = 1'b1;
    do_req(NVS_CMD_READ, 13'h0155, 8'h00, l);
    chk(16'(rd_data_out), 16'h0012);
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      $display("Error at %0t: cycles %h limit %h", $time, cyc, 3000);
      failures++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(negedge mclk_in);
    rstn_in = 1'b1;
    sc_rw;
    sc_nv(NVS_CMD_STORE);
    sc_nv(NVS_CMD_RECALL);
    sc_low;
    complete_run;
  end
endmodule // tb_nvsctl_host
`default_nettype wire
